// ### hw/pts_fifo.sv
/*
 Parallel-to-serial FIFO: asynchronous parallel load strobe, serial output
 shifted by an external serial clock, status flags, expansion token chain
 and an AXI4-Lite register slave.
 Assumes all device pins are asynchronous to aclk and sampled here; the serial clock
 runs well below a quarter of aclk so each of its edges is seen.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module pts_fifo (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [pts_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pts_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Device pins
   input wire logic write_strobe_n,
   input wire logic [pts_pkg::DATA_W-1:0] data_in,
   input wire logic serial_shift_clock,
   input wire logic first_load_select,
   input wire logic expansion_token_in,
   output logic expansion_token_out,
   output logic serial_out,
   output logic serial_out_oe_n,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic half_full_flag_n
);
   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   localparam int SYNC_W = pts_pkg::DATA_W + 4;

   logic [SYNC_W-1:0] sync_q;
   logic [pts_pkg::DATA_W-1:0] data_s;
   logic strobe_s;
   logic sclk_s;
   logic fl_s;
   logic token_s;

   pts_sync #(.W(SYNC_W)) u_sync (
      .aclk(aclk),
      .async_in({data_in, write_strobe_n, serial_shift_clock, first_load_select,
                 expansion_token_in}),
      .sync_out(sync_q)
   );

   assign data_s = sync_q[SYNC_W-1:4];
   assign strobe_s = sync_q[3];
   assign sclk_s = sync_q[2];
   assign fl_s = sync_q[1];
   assign token_s = sync_q[0];

   logic strobe_d;
   logic sclk_d;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_d <= 1'b1;
         sclk_d <= 1'b0;
      end else begin
         strobe_d <= strobe_s;
         sclk_d <= sclk_s;
      end
   end

   logic strobe_fall;
   logic strobe_rise;
   logic sclk_rise;

   assign strobe_fall = strobe_d & ~strobe_s;
   assign strobe_rise = ~strobe_d & strobe_s;
   assign sclk_rise = ~sclk_d & sclk_s;

   // ==========================================================
   // Mode straps, caught on the first cycle after reset
   // ==========================================================
   logic in_reset;
   logic strap_now;
   logic expansion;
   logic first_device;

   assign strap_now = in_reset;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_reset <= 1'b1;
         expansion <= 1'b0;
         first_device <= 1'b0;
      end else begin
         in_reset <= 1'b0;
         if (strap_now) begin
            expansion <= ~token_s;
            first_device <= ~fl_s;
         end
      end
   end

   // ==========================================================
   // Parallel write side
   // ==========================================================
   logic [pts_pkg::PTR_W-1:0] wr_ptr;
   logic [pts_pkg::PTR_W-1:0] rd_ptr;
   logic [pts_pkg::DATA_W-1:0] load_word;
   logic write_armed;
   logic wr_en;

   // Data sampled alongside the strobe, last value seen while low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_word <= '0;
      end else if (!strobe_s) begin
         load_word <= data_s;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         write_armed <= 1'b0;
      end else if (strobe_fall) begin
         write_armed <= full_flag_n;
      end else if (strobe_rise) begin
         write_armed <= 1'b0;
      end
   end

   assign wr_en = strobe_rise & write_armed;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
      end else if (wr_en) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // ==========================================================
   // Storage and prefetch into the staging word
   // ==========================================================
   logic [pts_pkg::PTR_W-1:0] mem_count;
   logic [pts_pkg::DATA_W-1:0] rd_data;
   logic fetch_now;
   logic fetch_pending;
   logic staged_valid;
   logic [pts_pkg::DATA_W-1:0] staged_word;
   logic take_word;

   assign mem_count = wr_ptr - rd_ptr;
   assign fetch_now = (mem_count != '0) & ~fetch_pending & ~staged_valid;

   // Write and read sides share no control
   pts_mem u_mem (
      .aclk(aclk),
      .wr_en(wr_en),
      .wr_addr(wr_ptr[pts_pkg::ADDR_W-1:0]),
      .wr_data(load_word),
      .rd_addr(rd_ptr[pts_pkg::ADDR_W-1:0]),
      .rd_data(rd_data)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ptr <= '0;
         fetch_pending <= 1'b0;
      end else begin
         fetch_pending <= fetch_now;
         if (fetch_now) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         staged_valid <= 1'b0;
         staged_word <= '0;
      end else if (fetch_pending) begin
         staged_valid <= 1'b1;
         staged_word <= rd_data;
      end else if (take_word) begin
         staged_valid <= 1'b0;
      end
   end

   // ==========================================================
   // Serial output and token chain
   // ==========================================================
   logic [pts_pkg::DATA_W-1:0] shift_word;
   logic [pts_pkg::POS_W-1:0] bit_pos;
   logic [pts_pkg::POS_W-1:0] next_pos;
   logic shift_active;
   logic msb_first;
   logic has_token;
   logic may_shift;
   logic token_q;
   logic shift_bit;

   function automatic logic pick_bit(input logic [pts_pkg::DATA_W-1:0] word,
                                     input logic [pts_pkg::POS_W-1:0] pos,
                                     input logic msb);
      pick_bit = msb ? word[pts_pkg::LAST_POS - pos] : word[pos];
   endfunction

   assign next_pos = bit_pos + 1'b1;
   assign may_shift = has_token | (expansion & token_s);
   assign take_word = sclk_rise & ~shift_active & staged_valid & may_shift;
   assign shift_bit = sclk_rise & (shift_active | take_word);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_word <= '0;
         bit_pos <= pts_pkg::FIRST_POS;
         shift_active <= 1'b0;
         msb_first <= 1'b0;
         serial_out <= 1'b0;
      end else if (sclk_rise && shift_active) begin
         serial_out <= pick_bit(shift_word, next_pos, msb_first);
         bit_pos <= next_pos;
         shift_active <= (next_pos != pts_pkg::LAST_POS);
      end else if (take_word) begin
         shift_word <= staged_word;
         msb_first <= fl_s;
         serial_out <= pick_bit(staged_word, pts_pkg::FIRST_POS, fl_s);
         bit_pos <= pts_pkg::FIRST_POS;
         shift_active <= 1'b1;
      end
   end

   logic word_done;

   assign word_done = sclk_rise & shift_active & (next_pos == pts_pkg::LAST_POS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         has_token <= 1'b0;
         token_q <= 1'b0;
      end else if (strap_now) begin
         has_token <= token_s | ~fl_s;
         token_q <= 1'b0;
      end else if (expansion) begin
         if (word_done) begin
            has_token <= 1'b0;
            token_q <= 1'b1;
         end else begin
            if (sclk_rise) begin
               token_q <= 1'b0;
            end
            if (sclk_rise && token_s) begin
               has_token <= 1'b1;
            end
         end
      end
   end

   // Pin floats until the first bit; in expansion only while shifting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_out_oe_n <= 1'b1;
      end else if (expansion) begin
         if (sclk_rise) begin
            serial_out_oe_n <= ~shift_bit;
         end
      end else if (shift_bit) begin
         serial_out_oe_n <= 1'b0;
      end
   end

   // ==========================================================
   // Status flags
   // ==========================================================
   logic [pts_pkg::OCC_W-1:0] occupancy;
   logic [pts_pkg::ADDR_W-1:0] almost_level;
   logic almost_n;

   assign occupancy = {1'b0, mem_count} + {{(pts_pkg::OCC_W-1){1'b0}}, fetch_pending}
                      + {{(pts_pkg::OCC_W-1){1'b0}}, staged_valid};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         empty_flag_n <= 1'b0;
         full_flag_n <= 1'b1;
         half_full_flag_n <= 1'b1;
         almost_n <= 1'b0;
      end else begin
         empty_flag_n <= (occupancy != '0);
         full_flag_n <= (mem_count != pts_pkg::DEPTH_PTR);
         half_full_flag_n <= ~(occupancy > pts_pkg::HALF_OCC);
         almost_n <= ~((occupancy <= {2'b00, almost_level})
                       | (occupancy >= pts_pkg::DEPTH_OCC - {2'b00, almost_level}));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         expansion_token_out <= 1'b0;
      end else if (expansion) begin
         expansion_token_out <= token_q;
      end else begin
         expansion_token_out <= almost_n;
      end
   end

   // ==========================================================
   // AXI4-Lite write channel
   // ==========================================================
   logic aw_held;
   logic w_held;
   logic [pts_pkg::AXI_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pts_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr == pts_pkg::STATUS_OFS || aw_addr == pts_pkg::LEVEL_OFS
                         || aw_addr == pts_pkg::ALMOST_OFS)
                        ? pts_pkg::RESP_OKAY : pts_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Threshold register, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         almost_level <= pts_pkg::ALMOST_RESET;
      end else if (do_write && aw_addr == pts_pkg::ALMOST_OFS) begin
         if (w_strb[0]) begin
            almost_level[7:0] <= w_data[7:0];
         end
         if (w_strb[1]) begin
            almost_level[pts_pkg::ADDR_W-1:8] <= w_data[pts_pkg::ADDR_W-1:8];
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   // ==========================================================
   logic [pts_pkg::ST_W-1:0] status;

   always_comb begin
      status = '0;
      status[pts_pkg::ST_EMPTY] = ~empty_flag_n;
      status[pts_pkg::ST_FULL] = ~full_flag_n;
      status[pts_pkg::ST_HALF] = ~half_full_flag_n;
      status[pts_pkg::ST_ALMOST] = ~almost_n;
      status[pts_pkg::ST_EXPAND] = expansion;
      status[pts_pkg::ST_FIRST] = first_device;
      status[pts_pkg::ST_TOKEN] = has_token;
      status[pts_pkg::ST_DRIVE] = ~serial_out_oe_n;
   end

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= pts_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= pts_pkg::RESP_OKAY;
         case (s_axi_araddr)
            pts_pkg::STATUS_OFS: s_axi_rdata <= {{(32-pts_pkg::ST_W){1'b0}}, status};
            pts_pkg::LEVEL_OFS: s_axi_rdata <= {{(32-pts_pkg::OCC_W){1'b0}}, occupancy};
            pts_pkg::ALMOST_OFS: s_axi_rdata <= {{(32-pts_pkg::ADDR_W){1'b0}}, almost_level};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= pts_pkg::RESP_DECERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // pts_fifo

// ### hw/pts_mem.sv
/*
 Storage array for the FIFO words, one write and one registered read port.
 Assumes the controller never reads and writes the same entry in one cycle.
*/
`timescale 1ns/1ps
module pts_mem (
   input wire logic aclk,
   input wire logic wr_en,
   input wire logic [pts_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [pts_pkg::DATA_W-1:0] wr_data,
   input wire logic [pts_pkg::ADDR_W-1:0] rd_addr,
   output logic [pts_pkg::DATA_W-1:0] rd_data
);
   logic [pts_pkg::DATA_W-1:0] store [pts_pkg::DEPTH];

   always_ff @(posedge aclk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge aclk) begin
      rd_data <= store[rd_addr];
   end
endmodule // pts_mem

// ### hw/pts_pkg.sv
/*
 Constants shared by the parallel-to-serial FIFO: widths, depth, flag
 thresholds, register offsets and bus response codes.
 Assumes a single 50 MHz system clock and an AXI4-Lite register master.
*/
// Function
// - Reset clears both pointers; empty and almost flags low, full and half-full high.
// - A write starts at the load strobe falling edge only when not full.
// - Strobe falling while full suppresses that write and keeps the write pointer.
// - Write pointer advances, with data taken, at the load strobe rising edge.
// - Parallel writes and serial reads run independently, no phase relation.
// - Each stored word arrives over sixteen parallel data lines, bits 0 to 15.
// - Each serial clock rising edge presents the next bit unless empty.
// - While empty no new word enters the output shift register.
// - Bit order select low gives least significant bit first, high most first.
// - Token input held high at reset selects single-device operation.
// - In single-device mode the shared pin carries the almost-empty/almost-full flag.
// - Single-device serial output floats only after reset; holds last bit when empty.
// - In expansion the serial output drives only while this device is shifting.
// - In expansion the shared pin is the token output; almost flag unavailable.
package pts_pkg;
   localparam int DATA_W = 16;
   localparam int DEPTH = 1024;
   localparam int ADDR_W = 10;
   localparam int PTR_W = ADDR_W + 1;
   localparam int OCC_W = PTR_W + 1;
   localparam int POS_W = 4;
   localparam logic [POS_W-1:0] LAST_POS = 4'hf;
   localparam logic [POS_W-1:0] FIRST_POS = 4'h0;
   localparam logic [OCC_W-1:0] DEPTH_OCC = 12'h400;
   localparam logic [OCC_W-1:0] HALF_OCC = 12'h200;
   localparam logic [PTR_W-1:0] DEPTH_PTR = 11'h400;
   localparam logic [ADDR_W-1:0] ALMOST_RESET = 10'h010;
   // Register map, byte addresses
   localparam int AXI_ADDR_W = 4;
   localparam logic [AXI_ADDR_W-1:0] STATUS_OFS = 4'h0;
   localparam logic [AXI_ADDR_W-1:0] LEVEL_OFS = 4'h4;
   localparam logic [AXI_ADDR_W-1:0] ALMOST_OFS = 4'h8;
   // Status register fields
   localparam int ST_EMPTY = 0;
   localparam int ST_FULL = 1;
   localparam int ST_HALF = 2;
   localparam int ST_ALMOST = 3;
   localparam int ST_EXPAND = 4;
   localparam int ST_FIRST = 5;
   localparam int ST_TOKEN = 6;
   localparam int ST_DRIVE = 7;
   localparam int ST_W = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// ### hw/pts_sync.sv
/*
 Two-stage synchroniser for a group of pins.
 Assumes the inputs are asynchronous to aclk; only stage two is read outside.
 Not reset, so the stages track the pins during reset and the straps and
 the strobe idle level are already valid on the first edge after release.
*/
`timescale 1ns/1ps
module pts_sync #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   always_ff @(posedge aclk) begin
      stage1 <= async_in;
      sync_out <= stage1;
   end
endmodule // pts_sync

// ### test/pts_far_end.sv
/*
 Serial consumer model: clocks out one word at a time, 160 ns period.
 Assumes the caller sets bit order before calling get_word.
*/
`timescale 1ns/1ps
module pts_far_end (
   output logic serial_shift_clock,
   input wire logic serial_out,
   input wire logic serial_out_oe_n
);
   // Clock stands low outside words
   initial serial_shift_clock = 1'b0;
   // ====
   // Bits in arrival order; undriven line reads unknown
   task automatic get_word(output logic [15:0] bits);
      for (int i = 0; i < 16; i++) begin
         #7 serial_shift_clock = 1'b1;
         #80 serial_shift_clock = 1'b0;
         #73 bits[i] = serial_out_oe_n ? 1'bx : serial_out;
      end
   endtask
endmodule // pts_far_end

// ### test/pts_fifo_asserts.sv
/*
 Port checker for pts_fifo: reset values, flags, serial timing, bus holds.
 Assumes one aclk domain with synchronous active-low aresetn.
*/
`timescale 1ns/1ps
module pts_fifo_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic write_strobe_n,
   input wire logic serial_shift_clock,
   input wire logic expansion_token_in,
   input wire logic expansion_token_out,
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   input wire logic empty_flag_n,
   input wire logic full_flag_n,
   input wire logic half_full_flag_n,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   logic prev_clk;
   logic [3:0] since_rise;
   // ====
   // Cycles since the serial clock pin rose
   always_ff @(posedge aclk) begin
      prev_clk <= serial_shift_clock;
      if (!aresetn) since_rise <= 4'hf;
      else if (serial_shift_clock && !prev_clk) since_rise <= 4'h0;
      else if (since_rise != 4'hf) since_rise <= since_rise + 4'h1;
   end
   sequence s_load_end;
      $rose(write_strobe_n) && full_flag_n;
   endsequence
   sequence s_word_seen;
      ##[1:8] empty_flag_n;
   endsequence
   // ====
   // Properties
   a_reset_flags: assert property (
      !aresetn |=> !empty_flag_n && full_flag_n && half_full_flag_n
         && !expansion_token_out && serial_out_oe_n)
      else $error("flags wrong after reset");
   a_load_lands: assert property (disable iff (!aresetn)
      s_load_end |-> s_word_seen)
      else $error("written word not flagged");
   a_serial_cause: assert property (disable iff (!aresetn)
      $changed(serial_out) |-> since_rise < 4'h6)
      else $error("serial output moved without clock");
   a_oe_keeps: assert property (disable iff (!aresetn)
      !serial_out_oe_n && expansion_token_in |=> !serial_out_oe_n)
      else $error("serial output released");
   a_full_half: assert property (disable iff (!aresetn)
      !full_flag_n |-> !half_full_flag_n)
      else $error("full without half");
   a_empty_half: assert property (disable iff (!aresetn)
      !empty_flag_n |-> half_full_flag_n)
      else $error("empty with half");
   a_bresp_hold: assert property (disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule // pts_fifo_asserts

bind pts_fifo pts_fifo_asserts i_chk (
   .aclk(aclk), .aresetn(aresetn), .write_strobe_n(write_strobe_n),
   .serial_shift_clock(serial_shift_clock), .expansion_token_in(expansion_token_in),
   .expansion_token_out(expansion_token_out), .serial_out(serial_out),
   .serial_out_oe_n(serial_out_oe_n), .empty_flag_n(empty_flag_n),
   .full_flag_n(full_flag_n), .half_full_flag_n(half_full_flag_n),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ### test/pts_fifo_tb_top.sv
/*
 Self-checking bench for pts_fifo: fill to full, serial drain, registers.
 Assumes pts_far_end as serial consumer and the bound port checker.
*/
`timescale 1ns/1ps
module pts_fifo_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awa = 4'h0;
   logic [3:0] ara = 4'h0;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic bre = 1'b0;
   logic arv = 1'b0;
   logic rre = 1'b0;
   logic strobe_n = 1'b1;
   logic [15:0] din = 16'h0;
   logic dir = 1'b0;
   logic tok_in = 1'b1;
   logic awr, wr, bv, arr, rv, sclk, sout, oe_n, tok_out, empty_n, full_n, half_n;
   logic [1:0] br, rr;
   logic [31:0] rd;
   logic [15:0] raw;
   logic [15:0] q[$];
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 32'hecdedda7;
   int cnt = 0;
   int cycles = 0;
   int thr = 32;

   pts_fifo i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .write_strobe_n(strobe_n),
      .data_in(din), .serial_shift_clock(sclk), .first_load_select(dir),
      .expansion_token_in(tok_in), .expansion_token_out(tok_out), .serial_out(sout),
      .serial_out_oe_n(oe_n), .empty_flag_n(empty_n), .full_flag_n(full_n),
      .half_full_flag_n(half_n)
   );
   pts_far_end i_far (.serial_shift_clock(sclk), .serial_out(sout), .serial_out_oe_n(oe_n));

   initial forever #10 aclk = ~aclk;
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         report_and_stop();
      end
   end
   // ====
   // Checking and bus tasks
   task automatic report_and_stop();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while ((awv && !awr) || (wv && !wr));
      do @(posedge aclk); while (!bv);
      bre <= 1'b0;
      chk("bresp", 32'(e), 32'(br));
   endtask
   task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er,
                         input logic [31:0] m, input string nm);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do @(posedge aclk); while (!arr);
      arv <= 1'b0;
      do @(posedge aclk); while (!rv);
      rre <= 1'b0;
      chk(nm, e, rd & m);
      chk("rresp", 32'(er), 32'(rr));
      @(posedge aclk);
   endtask
   // ====
   // Pin tasks and reference model
   task automatic load(input logic [15:0] d);
      @(posedge aclk);
      din <= d;
      strobe_n <= 1'b0;
      if (full_n) begin
         q.push_back(d);
         cnt++;
      end
      repeat (4) @(posedge aclk);
      strobe_n <= 1'b1;
      repeat (6) @(posedge aclk);
   endtask
   task automatic take_word(input logic msb);
      logic [15:0] w;
      logic [15:0] e;
      @(posedge aclk);
      dir <= msb;
      repeat (4) @(posedge aclk);
      i_far.get_word(raw);
      w = q.pop_front();
      cnt--;
      if (msb) e = {<<{w}};
      else e = w;
      chk("serial word", 32'(e), 32'(raw));
   endtask
   task automatic flags();
      chk("empty", 32'(cnt > 0), 32'(empty_n));
      chk("half", 32'(cnt <= pts_pkg::DEPTH / 2), 32'(half_n));
      chk("almost", 32'(!(cnt <= thr || cnt >= pts_pkg::DEPTH - thr)), 32'(tok_out));
   endtask
   // ====
   // Main sequence
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(pts_pkg::STATUS_OFS, 32'h9, pts_pkg::RESP_OKAY, 32'hf, "status");
      axi_rd(pts_pkg::ALMOST_OFS, 32'h10, pts_pkg::RESP_OKAY, 32'h3ff, "threshold");
      axi_wr(pts_pkg::ALMOST_OFS, 32'(thr), pts_pkg::RESP_OKAY);
      axi_rd(pts_pkg::ALMOST_OFS, 32'(thr), pts_pkg::RESP_OKAY, 32'h3ff, "threshold");
      axi_wr(4'hc, 32'h5, pts_pkg::RESP_DECERR);
      axi_rd(4'hc, 32'h0, pts_pkg::RESP_DECERR, 32'hffffffff, "unmapped");
      for (int i = 0; i < 1100 && full_n; i++) begin
         load(16'($random(seed)));
         flags();
      end
      chk("full", 32'h0, 32'(full_n));
      chk("capacity", 32'h1, 32'(cnt >= pts_pkg::DEPTH && cnt <= pts_pkg::DEPTH + 2));
      load(16'h5a5a);
      axi_rd(pts_pkg::LEVEL_OFS, 32'(cnt), pts_pkg::RESP_OKAY, 32'hfff, "level");
      fork
         for (int i = 0; i < 20; i++) take_word(1'(i % 2));
         begin
            repeat (200) @(posedge aclk);
            load(16'($random(seed)));
            load(16'($random(seed)));
         end
      join
      @(posedge aclk);
      aresetn <= 1'b0;
      dir <= 1'b0;
      q.delete();
      cnt = 0;
      thr = 32'(pts_pkg::ALMOST_RESET);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      flags();
      axi_rd(pts_pkg::LEVEL_OFS, 32'h0, pts_pkg::RESP_OKAY, 32'hfff, "level");
      load(16'h1234);
      load(16'hc001);
      take_word(1'b0);
      take_word(1'b1);
      repeat (10) @(posedge aclk);
      chk("drained", 32'h0, 32'(empty_n));
      chk("held bit", 32'h1, 32'(sout));
      chk("still driving", 32'h0, 32'(oe_n));
      report_and_stop();
   end
endmodule // pts_fifo_tb_top
